// File: rtl/cpa_map.svh
// Constants for the channel priority arbiter: ranks, widths, storage and termination figures
`ifndef CPA_MAP_SVH
`define CPA_MAP_SVH
`define CPA_NUM_RANKS 11
`define CPA_NUM_SEL 4
`define CPA_RANK_MUX 4
`define CPA_RANK_SEC0 5
`define CPA_RANK_MAIN 9
`define CPA_RANK_CPU 10
`define CPA_DW_BYTES 24'h000008
`define CPA_DW_COUNT 16'h0008
`define CPA_COUNT_ZERO 16'h0000
`define CPA_MAX_SUBCH 9'h0C4
`define CPA_MAX_DEVADR 9'h100
`define CPA_SEL_DEVS 5'h10
`define CPA_SEL_BASE 8'hC0
`define CPA_LOG_BASE 10'h3F0
`define CPA_LOG_WORDS 2'h3
`define CPA_PTR_ADR 24'h000048
`endif

// File: rtl/cpa_pkg.sv
// Types shared by the channel priority arbiter
package cpa_pkg;
  typedef enum logic [2:0] {
    CPA_IDLE = 3'b000,
    CPA_SEL_SUB = 3'b001,
    CPA_FETCH_PTR = 3'b010,
    CPA_FETCH_CMD = 3'b011,
    CPA_SEL_DEV = 3'b100,
    CPA_LOG = 3'b101
  } cpa_state_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] count;
    logic [7:0] unit;
    logic count_end;
    logic error;
  } cpa_status_type;

  typedef struct packed {
    logic req;
    logic [1:0] kind;
    logic [23:0] addr;
  } cpa_mem_req_type;
endpackage

// File: rtl/cpa_channel_priority_arbiter.sv
// Shared main-channel priority arbiter with address/count, start I/O, status and logout
`timescale 1ns/100ps
`include "cpa_map.svh"
// Overview of operation
// - At most one unit holds the shared main channel at any time.
// - Simultaneous requests go to the highest fixed rank; selector beats CPU.
// - Each selector subchannel requests at two rank levels by operation kind.
// - Selector doubleword requests rank one to four; grant does storage and update.
// - Service in or status in on the multiplex interface raises rank five.
// - Multiplex work: count per byte, address per doubleword.
// - Selector work: address and count change only on storage cycles.
// - Count decrements with data; reaching zero ends the operation.
// - Start I/O selects subchannel, fetches pointer and command words, selects device.
// - Multiplex bytes each use the channel; selectors only for doublewords.
// - All storage and CPU exchange passes through this block.
// - Operation end builds the ending status word.
// - A logout assembles log words and writes them to local storage.
// - A selector subchannel runs one of sixteen devices at a time.
// - At most 196 subchannels and 256 device addresses are accepted.
// - Selector secondary requests rank six to nine.
// - Main channel requests rank ten for instructions and reselection.
// - CPU request ranks lowest, eleventh, to store a status word.
module cpa_channel_priority_arbiter import cpa_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [3:0] sel_primary_req_in,
  input wire logic [3:0] sel_secondary_req_in,
  input wire logic svc_in_pin_in,
  input wire logic sta_in_pin_in,
  input wire logic reselect_need_in,
  input wire logic cpu_req_in,
  input wire logic release_in,
  input wire logic byte_moved_in,
  input wire logic dw_moved_in,
  input wire logic [23:0] load_addr_in,
  input wire logic [15:0] load_count_in,
  input wire logic load_in,
  input wire logic start_io_in,
  input wire logic [7:0] start_unit_in,
  input wire logic mem_ack_in,
  input wire logic [4:0] sel_done_in,
  input wire logic error_in,
  output logic [10:0] grant_out,
  output cpa_mem_req_type mem_req_out,
  output logic [7:0] dev_select_out,
  output logic dev_select_stb_out,
  output logic [2:0] subch_select_out,
  output logic start_reject_out,
  output logic end_stb_out,
  output cpa_status_type status_word_out,
  output logic ls_we_out,
  output logic [9:0] ls_addr_out,
  output logic [71:0] ls_wdata_out
);
  logic svc_meta, svc_sync, sta_meta, sta_sync;
  logic [23:0] addr;
  logic [15:0] count;
  logic [7:0] unit;
  logic sio_pending;
  logic [3:0] sel_busy;
  logic [1:0] log_idx;
  logic log_pending;
  cpa_state_type state;
  cpa_state_type next_state;
  logic unit_is_sel_q;
  // High in the first cycle of a grant; a selector grant draws one storage
  // cycle only, as a second one would still be running after the release
  logic grant_fresh;

  // Pins cross from the interface and pass two flops first
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {svc_meta, svc_sync, sta_meta, sta_sync} <= 4'h0;
    end else if (clk_en_in) begin
      {svc_meta, sta_meta} <= {svc_in_pin_in, sta_in_pin_in};
      {svc_sync, sta_sync} <= {svc_meta, sta_meta};
    end
  end

  wire [10:0] req_vec;
  assign req_vec[3:0] = sel_primary_req_in;
  assign req_vec[`CPA_RANK_MUX] = svc_sync | sta_sync;
  assign req_vec[8:5] = sel_secondary_req_in;
  assign req_vec[`CPA_RANK_MAIN] = sio_pending | reselect_need_in;
  assign req_vec[`CPA_RANK_CPU] = cpu_req_in;

  // Lowest index is highest rank; one-hot pick
  wire [10:0] pick = req_vec & (~req_vec + 11'h001);
  wire idle_grant = (grant_out == 11'h000);
  wire main_granted = grant_out[`CPA_RANK_MAIN];
  wire main_done = main_granted && (state == CPA_SEL_DEV || (state == CPA_IDLE && !sio_pending));
  wire do_release = !idle_grant && ((release_in && !main_granted) || main_done);

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      grant_out <= 11'h000;
      grant_fresh <= 1'b0;
    end else if (clk_en_in) begin
      grant_fresh <= idle_grant && (pick != 11'h000);
      if (idle_grant) begin
        grant_out <= pick;
      end else if (do_release) begin
        grant_out <= 11'h000;
      end
    end
  end

  // Address/count housekeeping for the granted unit
  wire sel_primary_g = |grant_out[3:0];
  wire mux_g = grant_out[`CPA_RANK_MUX] | (main_granted & reselect_need_in);
  wire cnt_byte = mux_g && byte_moved_in;
  wire adr_dw = (mux_g && dw_moved_in) || (sel_primary_g && mem_ack_in);
  wire cnt_dw = sel_primary_g && mem_ack_in;
  wire [15:0] cnt_step = cnt_dw ? `CPA_DW_COUNT : 16'h0001;
  wire cnt_dec = cnt_byte || cnt_dw;
  wire cnt_hits_zero = cnt_dec && (count <= cnt_step);
  wire [15:0] next_count = cnt_hits_zero ? `CPA_COUNT_ZERO : count - cnt_step;
  wire [23:0] next_addr = addr + `CPA_DW_BYTES;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr <= 24'h000000;
      count <= 16'h0000;
    end else if (clk_en_in) begin
      if (load_in) begin
        addr <= load_addr_in;
        count <= load_count_in;
      end else begin
        if (adr_dw) addr <= next_addr;
        if (cnt_dec && count != `CPA_COUNT_ZERO) count <= next_count;
      end
    end
  end

  // Ending status word, also on a logout
  wire end_event = (cnt_dec && count != `CPA_COUNT_ZERO && cnt_hits_zero) || error_in;
  // Report the address as it stands after this cycle's step
  wire [23:0] end_addr = (adr_dw && !load_in) ? next_addr : addr;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      end_stb_out <= 1'b0;
      status_word_out <= '0;
    end else if (clk_en_in) begin
      end_stb_out <= end_event;
      if (end_event) begin
        status_word_out <= '{addr: end_addr, count: cnt_hits_zero ? `CPA_COUNT_ZERO : count,
          unit: unit, count_end: cnt_hits_zero, error: error_in};
      end
    end
  end

  // Start I/O acceptance; selectors run only one device at a time
  wire [8:0] unit_ext = {1'b0, start_unit_in};
  wire unit_is_sel = start_unit_in >= `CPA_SEL_BASE;
  wire [1:0] sel_num = start_unit_in[5:4];
  wire unit_ok = unit_ext < `CPA_MAX_DEVADR;
  wire sel_clash = unit_is_sel && sel_busy[sel_num];
  wire sio_accept = start_io_in && !sio_pending && unit_ok && !sel_clash;
  wire [3:0] sel_set = (state == CPA_SEL_DEV && unit_is_sel_q) ? (4'h1 << unit[5:4]) : 4'h0;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sio_pending <= 1'b0;
      unit <= 8'h00;
      unit_is_sel_q <= 1'b0;
      sel_busy <= 4'h0;
      start_reject_out <= 1'b0;
    end else if (clk_en_in) begin
      start_reject_out <= start_io_in && !sio_accept;
      if (sio_accept) begin
        sio_pending <= 1'b1;
        unit <= start_unit_in;
        unit_is_sel_q <= unit_is_sel;
      end else if (state == CPA_SEL_DEV) begin
        sio_pending <= 1'b0;
      end
      // Set wins over a simultaneous done
      sel_busy <= (sel_busy & ~sel_done_in[3:0]) | sel_set;
    end
  end

  // Main channel sequence: start I/O steps and logout
  wire mem_wait = mem_req_out.req && !mem_ack_in;
  always_comb begin
    next_state = state;
    case (state)
      CPA_IDLE: begin
        if (log_pending) next_state = CPA_LOG;
        else if (main_granted && sio_pending) next_state = CPA_SEL_SUB;
      end
      CPA_SEL_SUB: next_state = CPA_FETCH_PTR;
      CPA_FETCH_PTR: if (mem_ack_in) next_state = CPA_FETCH_CMD;
      CPA_FETCH_CMD: if (mem_ack_in) next_state = CPA_SEL_DEV;
      CPA_SEL_DEV: next_state = CPA_IDLE;
      CPA_LOG: if (log_idx == `CPA_LOG_WORDS) next_state = CPA_IDLE;
      default: next_state = CPA_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= CPA_IDLE;
      mem_req_out <= '0;
      dev_select_out <= 8'h00;
      dev_select_stb_out <= 1'b0;
      subch_select_out <= 3'h0;
    end else if (clk_en_in) begin
      state <= next_state;
      dev_select_stb_out <= (next_state == CPA_SEL_DEV);
      if (next_state == CPA_SEL_DEV) dev_select_out <= unit;
      if (state == CPA_SEL_SUB) begin
        // Selector subchannels 1-4 as 1-4, multiplex path as 0
        subch_select_out <= unit_is_sel_q ? {1'b0, unit[5:4]} + 3'h1 : 3'h0;
      end
      if (next_state == CPA_FETCH_PTR && !mem_wait) begin
        mem_req_out <= '{req: 1'b1, kind: 2'h1, addr: `CPA_PTR_ADR};
      end else if (next_state == CPA_FETCH_CMD && state == CPA_FETCH_PTR) begin
        mem_req_out <= '{req: 1'b1, kind: 2'h2, addr: addr};
      end else if (sel_primary_g && grant_fresh) begin
        mem_req_out <= '{req: 1'b1, kind: 2'h3, addr: addr};
      end else if (mem_ack_in) begin
        mem_req_out <= '0;
      end
    end
  end

  // Logout writes three log words into local storage
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      log_pending <= 1'b0;
      log_idx <= 2'h0;
      ls_we_out <= 1'b0;
      ls_addr_out <= 10'h000;
      ls_wdata_out <= 72'h0;
    end else if (clk_en_in) begin
      ls_we_out <= 1'b0;
      if (error_in) log_pending <= 1'b1;
      if (state == CPA_LOG) begin
        log_pending <= error_in;
        if (log_idx != `CPA_LOG_WORDS) begin
          ls_we_out <= 1'b1;
          ls_addr_out <= `CPA_LOG_BASE + {8'h00, log_idx};
          ls_wdata_out <= {log_idx, 3'h0, grant_out, unit, count, addr, 8'h00};
          log_idx <= log_idx + 2'h1;
        end else begin
          log_idx <= 2'h0;
        end
      end
    end
  end

  onehot_grant_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $onehot0(grant_out)) else $error("more than one unit granted");
  rank_order_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && idle_grant && |req_vec |=> grant_out == $past(pick))
    else $error("grant not to highest rank");
  sel_beats_cpu_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && idle_grant && sel_primary_req_in[0] && cpu_req_in |=> grant_out[0])
    else $error("selector lost to cpu");
  mux_rank_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && idle_grant && (svc_sync || sta_sync) && sel_primary_req_in == 4'h0
    |=> grant_out[`CPA_RANK_MUX]) else $error("multiplex request not granted");
  grant_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && !idle_grant && !do_release |=> $stable(grant_out))
    else $error("grant dropped early");
  count_zero_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && !load_in && cnt_dec && count == 16'h0001 && !cnt_dw |=> count == 16'h0000
    && end_stb_out) else $error("count end missed");
  addr_step_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && !load_in && sel_primary_g && mem_ack_in |=> addr == $past(addr) + 24'h8)
    else $error("selector address not stepped");
  sel_one_access_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && sel_primary_g && mem_ack_in |=> !mem_req_out.req ##1 !mem_req_out.req)
    else $error("second storage cycle on one grant");
  sio_seq_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && state == CPA_SEL_SUB |=> state == CPA_FETCH_PTR && mem_req_out.kind == 2'h1)
    else $error("start sequence out of order");
  log_write_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clk_en_in && state == CPA_LOG && log_idx == 2'h0 |=> ls_we_out
    && ls_addr_out == `CPA_LOG_BASE) else $error("log word not written");
endmodule

// File: bench/cpa_storage_model.sv
// Behavioural main storage that answers the arbiter's storage requests
`timescale 1ns/100ps
module cpa_storage_model import cpa_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic slow_in,
  input wire cpa_mem_req_type mem_req_in,
  output logic mem_ack_out
);
  logic [3:0] wait_cnt;
  logic cool_down;
  wire logic [3:0] latency = slow_in ? 4'h6 : 4'h1;
  // A request still up just after an answer must not draw a second answer
  wire logic idle = !mem_req_in.req || mem_ack_out || cool_down;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_cnt <= 4'h0;
      mem_ack_out <= 1'b0;
      cool_down <= 1'b0;
    end else begin
      cool_down <= mem_ack_out;
      mem_ack_out <= !idle && wait_cnt == latency;
      wait_cnt <= (idle || wait_cnt == latency) ? 4'h0 : wait_cnt + 4'h1;
    end
  end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the channel priority arbiter
`timescale 1ns/100ps
module testbench import cpa_pkg::*;;
  logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1, slow = 1'b0;
  logic [3:0] sel_primary_req_in = 4'h0, sel_secondary_req_in = 4'h0;
  logic svc_in_pin_in = 1'b0, sta_in_pin_in = 1'b0, reselect_need_in = 1'b0;
  logic cpu_req_in = 1'b0, release_in = 1'b0, byte_moved_in = 1'b0, dw_moved_in = 1'b0;
  logic [23:0] load_addr_in = 24'h0;
  logic [15:0] load_count_in = 16'h0;
  logic load_in = 1'b0, start_io_in = 1'b0, error_in = 1'b0, mem_ack_in;
  logic [7:0] start_unit_in = 8'h0, dev_select_out;
  logic [4:0] sel_done_in = 5'h0;
  logic [10:0] grant_out;
  cpa_mem_req_type mem_req_out;
  logic dev_select_stb_out, start_reject_out, end_stb_out, ls_we_out;
  logic [2:0] subch_select_out;
  cpa_status_type status_word_out, last_st;
  logic [9:0] ls_addr_out;
  logic [71:0] ls_wdata_out;
  logic end_seen = 1'b0;
  logic [9:0] log_q[$];
  int fail_count = 0, tests_run = 0;
  cpa_channel_priority_arbiter DUT (.sys_clk_in, .sys_rst_in, .clk_en_in,
    .sel_primary_req_in, .sel_secondary_req_in, .svc_in_pin_in, .sta_in_pin_in,
    .reselect_need_in, .cpu_req_in, .release_in, .byte_moved_in, .dw_moved_in,
    .load_addr_in, .load_count_in, .load_in, .start_io_in, .start_unit_in, .mem_ack_in,
    .sel_done_in, .error_in, .grant_out, .mem_req_out, .dev_select_out,
    .dev_select_stb_out, .subch_select_out, .start_reject_out, .end_stb_out,
    .status_word_out, .ls_we_out, .ls_addr_out, .ls_wdata_out);
  cpa_storage_model storage (.sys_clk_in, .sys_rst_in, .slow_in(slow),
    .mem_req_in(mem_req_out), .mem_ack_out(mem_ack_in));
  always #2.5 sys_clk_in = ~sys_clk_in;
  // Pulsed results are latched so a scenario may look at them later
  always @(posedge sys_clk_in) begin
    if (end_stb_out) begin
      end_seen <= 1'b1;
      last_st <= status_word_out;
    end
    if (ls_we_out) log_q.push_back(ls_addr_out);
  end
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic flag(int w);
    case (w)
      0: return end_seen;
      1: return mem_ack_in;
      2: return dev_select_stb_out;
      3: return start_reject_out;
      default: return log_q.size() >= 3;
    endcase
  endfunction
  task automatic wait_flag(int w, string what);
    int i;
    for (i = 0; i < 60 && flag(w) !== 1'b1; i++) @(negedge sys_clk_in);
    chk(what, 24'h1, 24'(flag(w)));
    if (flag(w) !== 1'b1) end_of_test();
  endtask
  task automatic wait_grant(logic [10:0] exp);
    int i;
    for (i = 0; i < 60 && grant_out !== exp; i++) @(negedge sys_clk_in);
    chk("grant_out", 24'(exp), 24'(grant_out));
    if (grant_out !== exp) end_of_test();
  endtask
  task automatic wait_mem(logic [1:0] kind);
    int i;
    for (i = 0; i < 60 && !(mem_req_out.req === 1'b1 && mem_req_out.kind === kind); i++)
      @(negedge sys_clk_in);
    chk("mem_req_out kind", 24'(kind), 24'(mem_req_out.kind));
    if (mem_req_out.req !== 1'b1) end_of_test();
  endtask
  task automatic let_go();
    @(posedge sys_clk_in) release_in <= 1'b1;
    @(posedge sys_clk_in) release_in <= 1'b0;
  endtask
  task automatic freeze();
    @(posedge sys_clk_in);
    clk_en_in <= 1'b0;
    sta_in_pin_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk("frozen grant_out", 24'h0, 24'(grant_out));
    clk_en_in <= 1'b1;
    wait_grant(11'h010);
    @(posedge sys_clk_in) sta_in_pin_in <= 1'b0;
    let_go();
    wait_grant(11'h000);
  endtask
  task automatic reselect();
    @(posedge sys_clk_in) reselect_need_in <= 1'b1;
    wait_grant(11'h200);
    @(posedge sys_clk_in) reselect_need_in <= 1'b0;
    wait_grant(11'h000);
  endtask
  task automatic load(logic [23:0] a, logic [15:0] c);
    @(posedge sys_clk_in);
    load_addr_in <= a;
    load_count_in <= c;
    load_in <= 1'b1;
    end_seen <= 1'b0;
    @(posedge sys_clk_in) load_in <= 1'b0;
  endtask
  task automatic rank_order();
    logic [10:0] want [9] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h020, 11'h040,
      11'h080, 11'h100, 11'h400};
    int k;
    @(posedge sys_clk_in);
    {cpu_req_in, sel_secondary_req_in, sel_primary_req_in} <= 9'h1FF;
    for (k = 0; k < 9; k++) begin
      wait_grant(want[k]);
      @(posedge sys_clk_in);
      {cpu_req_in, sel_secondary_req_in, sel_primary_req_in} <=
        {cpu_req_in, sel_secondary_req_in, sel_primary_req_in} & ~(9'h001 << k);
      let_go();
    end
    wait_grant(11'h000);
  endtask
  task automatic mux_path();
    load(24'h000100, 16'h0002);
    @(posedge sys_clk_in) svc_in_pin_in <= 1'b1;
    wait_grant(11'h010);
    @(posedge sys_clk_in) svc_in_pin_in <= 1'b0;
    byte_moved_in <= 1'b1;
    @(posedge sys_clk_in) byte_moved_in <= 1'b0;
    dw_moved_in <= 1'b1;
    @(posedge sys_clk_in) dw_moved_in <= 1'b0;
    byte_moved_in <= 1'b1;
    @(posedge sys_clk_in) byte_moved_in <= 1'b0;
    wait_flag(0, "end_stb_out");
    chk("mux address", 24'h000108, last_st.addr);
    chk("mux count", 24'h0, 24'(last_st.count));
    chk("mux count_end", 24'h1, 24'(last_st.count_end));
    let_go();
    wait_grant(11'h000);
  endtask
  task automatic sel_xfer(logic [23:0] a);
    @(posedge sys_clk_in) sel_primary_req_in[1] <= 1'b1;
    wait_grant(11'h002);
    @(posedge sys_clk_in) sel_primary_req_in[1] <= 1'b0;
    wait_mem(2'h3);
    chk("selector address", a, mem_req_out.addr);
    wait_flag(1, "mem_ack_in");
    let_go();
    wait_grant(11'h000);
  endtask
  task automatic sel_path();
    load(24'h000200, 16'h0010);
    slow <= 1'b1;
    sel_xfer(24'h000200);
    chk("early end", 24'h0, 24'(end_seen));
    slow <= 1'b0;
    sel_xfer(24'h000208);
    wait_flag(0, "end_stb_out");
    chk("selector address", 24'h000210, last_st.addr);
    chk("selector count", 24'h0, 24'(last_st.count));
  endtask
  task automatic start(logic [7:0] u);
    @(posedge sys_clk_in);
    start_unit_in <= u;
    start_io_in <= 1'b1;
    @(posedge sys_clk_in) start_io_in <= 1'b0;
  endtask
  task automatic start_io();
    start(8'hC5);
    wait_grant(11'h200);
    wait_mem(2'h1);
    chk("pointer address", 24'h000048, mem_req_out.addr);
    wait_mem(2'h2);
    wait_flag(2, "dev_select_stb_out");
    chk("dev_select_out", 24'h0000C5, 24'(dev_select_out));
    chk("subch_select_out", 24'h1, 24'(subch_select_out));
    wait_grant(11'h000);
    start(8'hC9);
    wait_flag(3, "start_reject_out");
    @(posedge sys_clk_in) sel_done_in <= 5'h01;
    @(posedge sys_clk_in) sel_done_in <= 5'h00;
    start(8'hC9);
    wait_flag(2, "dev_select_stb_out");
    chk("dev_select_out", 24'h0000C9, 24'(dev_select_out));
  endtask
  task automatic logout();
    wait_grant(11'h000);
    @(posedge sys_clk_in) end_seen <= 1'b0;
    log_q.delete();
    error_in <= 1'b1;
    @(posedge sys_clk_in) error_in <= 1'b0;
    wait_flag(0, "end_stb_out");
    chk("status error", 24'h1, 24'(last_st.error));
    chk("status unit", 24'hC9, 24'(last_st.unit));
    wait_flag(4, "ls_we_out");
    chk("log word 0", 24'h3F0, 24'(log_q[0]));
    chk("log word 1", 24'h3F1, 24'(log_q[1]));
    chk("log word 2", 24'h3F2, 24'(log_q[2]));
    chk("log data unit", 24'hC9, 24'(ls_wdata_out[55:48]));
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rank_order();
    freeze();
    reselect();
    mux_path();
    sel_path();
    start_io();
    logout();
    end_of_test();
  end
endmodule
